/* File: logic/tst_trigger_ctrl.sv */
// slave-mode trigger control of a general-purpose timer, with AHB-Lite registers
//
// Overview of operation
// RQ1 - external trigger after division must stay at or below a quarter of timer clock.
// RQ2 - external trigger is divided by 1, 2, 4 or 8 per the divider field.
// RQ3 - filter is an event counter validating output after N consecutive samples.
// RQ4 - filter code 0 is unfiltered; codes 1..3 sample every clock, N 2, 4, 8.
// RQ5 - codes 4..9 sample at base clock /2, /4, /8, N 6 or 8.
// RQ6 - codes 10..12 sample /16, 13..15 /32, N 5, 6, 8.
// RQ7 - sync delay bit holds trigger events back one cycle for timer alignment.
// RQ8 - source field picks internal triggers 0..3, ch1 edge, ch1, ch2, external.
// RQ9 - software changes trigger source only while follower mode is disabled.
// RQ10 - mode 0 with run bit counts on the kernel clock; modes 1..3 reserved.
// RQ11 - reset mode: trigger rising edge reinitialises counter and updates shadows.
// RQ12 - gated mode: counter counts only while trigger is high, holds otherwise.
// RQ13 - trigger mode: rising edge starts the counter without resetting it.
// RQ14 - external clock mode 1: each trigger rising edge advances the counter.
// RQ15 - software never uses gated mode with the ch1 edge pulse source.
// RQ16 - external inputs set the active edge through their own selected polarity.
// RQ17 - trigger mode sets run bit by hardware; gated and clock modes need it set.
// RQ18 - event flag sets on active edge, or any edge in gated mode; software clears.
// RQ19 - external polarity 0 means high/rising active, 1 means low/falling active.
// RQ20 - filter count restarts on disagreement; output changes after N agreeing samples.
`timescale 1ns/1ps
module tst_trigger_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// trigger sources
	input wire logic ext_trig_pin,
	input wire logic internal_trigger_0,
	input wire logic internal_trigger_1,
	input wire logic internal_trigger_2,
	input wire logic internal_trigger_3,
	input wire logic ch1_edge_pulse,
	input wire logic ch1_filtered_input,
	input wire logic ch2_filtered_input,
	// counter core controls
	output logic counter_tick,
	output logic counter_reinit,
	output logic counter_run_bit,
	output logic trigger_event_flag
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	tst_pkg::tst_bus_type bus_ff, nxt_bus;
	logic [7:0] addr_ff, nxt_addr;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ready_ff, nxt_ready;
	logic take;
	logic wr_now;
	logic [31:0] rd_mux;

	tst_pkg::tst_mode_reg_type mode_ff, nxt_mode;
	logic run_ff, nxt_run;
	logic flag_ff, nxt_flag;
	tst_pkg::tst_evt_type eff_ff, nxt_eff;

	// size is not checked: only whole-word transfers are expected
	always_comb begin
		take = hsel && htrans[1] && hready;
		wr_now = bus_ff == tst_pkg::BUS_WRITE;
		nxt_bus = bus_ff;
		nxt_addr = addr_ff;
		nxt_rdata = rdata_ff;
		rd_mux = 32'h0000_0000;
		if (addr_ff == tst_pkg::CTRL_OFS) begin
			rd_mux[tst_pkg::RUN_BIT_POS] = run_ff;
		end else if (addr_ff == tst_pkg::MODE_OFS) begin
			rd_mux[15:0] = mode_ff;
		end else if (addr_ff == tst_pkg::STAT_OFS) begin
			rd_mux[tst_pkg::FLAG_BIT_POS] = flag_ff;
			rd_mux[tst_pkg::LEVEL_BIT_POS] = eff_ff.level;
		end
		case (bus_ff)
			tst_pkg::BUS_RWAIT: begin
				nxt_rdata = rd_mux;
				nxt_bus = tst_pkg::BUS_RDATA;
			end
			default: begin
				if (take) begin
					nxt_addr = haddr[7:0];
					nxt_bus = hwrite ? tst_pkg::BUS_WRITE : tst_pkg::BUS_RWAIT;
				end else begin
					nxt_bus = tst_pkg::BUS_IDLE;
				end
			end
		endcase
		// one wait state on reads so a write just ahead is already visible
		nxt_ready = nxt_bus != tst_pkg::BUS_RWAIT;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ff <= tst_pkg::BUS_IDLE;
			addr_ff <= 8'h00;
			rdata_ff <= tst_pkg::RDATA_RESET;
			ready_ff <= 1'b1;
		end else begin
			bus_ff <= nxt_bus;
			addr_ff <= nxt_addr;
			rdata_ff <= nxt_rdata;
			ready_ff <= nxt_ready;
		end
	end

	assign hrdata = rdata_ff;
	assign hreadyout = ready_ff;
	assign hresp = 1'b0;

	read_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && !hwrite |=> !ready_ff ##1 ready_ff)
		else $error("read did not answer after one wait state");

	// writes never stall: the data phase lands in the very next cycle
	write_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && hwrite |=> ready_ff)
		else $error("write data phase stalled");

	// ----------------------------------------------------------------
	// external trigger path
	// ----------------------------------------------------------------
	logic ext_pol;
	logic ext_trig_divided;
	logic ext_trig_filtered;

	assign ext_pol = ext_trig_pin ^ mode_ff.ext_trig_polarity; // [RQ19] [RQ16]

	tst_ext_prescaler u_prescaler (
		.clk(clk),
		.rst_n(rst_n),
		.divider_sel(mode_ff.ext_trig_divider_sel),
		.trig_in(ext_pol),
		.trig_out(ext_trig_divided)
	);

	tst_ext_filter u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.filter_sel(mode_ff.ext_trig_filter_sel),
		.trig_in(ext_trig_divided),
		.trig_out(ext_trig_filtered)
	);

	// ----------------------------------------------------------------
	// source select, edge detect and sync delay
	// ----------------------------------------------------------------
	logic trigger_input;
	logic prev_ff, nxt_prev;
	tst_pkg::tst_evt_type now_evt, dly_ff, nxt_dly;

	// ch1 and ch2 inputs arrive with their channel polarity already applied
	always_comb begin
		case (tst_pkg::tst_src_type'(mode_ff.trigger_source_sel))
			tst_pkg::SRC_INT0: trigger_input = internal_trigger_0; // [RQ8]
			tst_pkg::SRC_INT1: trigger_input = internal_trigger_1;
			tst_pkg::SRC_INT2: trigger_input = internal_trigger_2;
			tst_pkg::SRC_INT3: trigger_input = internal_trigger_3;
			tst_pkg::SRC_CH1_EDGE: trigger_input = ch1_edge_pulse;
			tst_pkg::SRC_CH1_FILT: trigger_input = ch1_filtered_input; // [RQ16]
			tst_pkg::SRC_CH2_FILT: trigger_input = ch2_filtered_input; // [RQ16]
			default: trigger_input = ext_trig_filtered;
		endcase
		nxt_prev = trigger_input;
		now_evt.level = trigger_input;
		now_evt.rise = trigger_input && !prev_ff;
		now_evt.fall = !trigger_input && prev_ff;
		nxt_dly = now_evt;
		// extra stage lines this timer up with the slaves it drives
		nxt_eff = mode_ff.sync_delay_enable ? dly_ff : now_evt; // [RQ7]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			dly_ff <= '0;
			eff_ff <= '0;
		end else begin
			prev_ff <= nxt_prev;
			dly_ff <= nxt_dly;
			eff_ff <= nxt_eff;
		end
	end

	sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
		mode_ff.sync_delay_enable && $stable(mode_ff) ##1 mode_ff.sync_delay_enable && $stable(mode_ff)
		|-> eff_ff == $past(now_evt, 2))
		else $error("delayed trigger event misaligned");

	source_ext_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
		mode_ff.trigger_source_sel == 3'h7 |-> trigger_input == ext_trig_filtered)
		else $error("external trigger not selected");

	// ----------------------------------------------------------------
	// registers and follower modes
	// ----------------------------------------------------------------
	tst_pkg::tst_mode_type mode_sel;
	logic tick_ff, nxt_tick;
	logic reinit_ff, nxt_reinit;
	logic flag_set;

	always_comb begin
		mode_sel = tst_pkg::tst_mode_type'(mode_ff.follower_mode_sel);
		nxt_mode = mode_ff;
		nxt_run = run_ff;
		nxt_flag = flag_ff;
		if (wr_now && addr_ff == tst_pkg::MODE_OFS) begin
			nxt_mode = hwdata[15:0];
			nxt_mode.ext_clk2_rsvd = 1'b0;
			nxt_mode.rsvd = 1'b0;
		end
		if (wr_now && addr_ff == tst_pkg::CTRL_OFS) begin
			nxt_run = hwdata[tst_pkg::RUN_BIT_POS];
		end
		if (wr_now && addr_ff == tst_pkg::STAT_OFS && !hwdata[tst_pkg::FLAG_BIT_POS]) begin
			nxt_flag = 1'b0; // [RQ18]
		end
		if (mode_sel == tst_pkg::SM_TRIGGER && eff_ff.rise) begin
			nxt_run = 1'b1; // [RQ13] [RQ17]
		end
		if (mode_sel == tst_pkg::SM_GATED) begin
			flag_set = eff_ff.rise || eff_ff.fall; // [RQ18]
		end else begin
			flag_set = eff_ff.rise; // [RQ18]
		end
		if (flag_set) begin
			nxt_flag = 1'b1;
		end
		nxt_reinit = mode_sel == tst_pkg::SM_RESET && eff_ff.rise; // [RQ11]
		case (mode_sel)
			tst_pkg::SM_GATED: nxt_tick = run_ff && eff_ff.level; // [RQ12] [RQ17]
			tst_pkg::SM_EXTCLK: nxt_tick = run_ff && eff_ff.rise; // [RQ14] [RQ17]
			default: nxt_tick = run_ff; // [RQ10]
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= tst_pkg::MODE_RESET;
			run_ff <= tst_pkg::RUN_RESET;
			flag_ff <= tst_pkg::FLAG_RESET;
			tick_ff <= 1'b0;
			reinit_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			run_ff <= nxt_run;
			flag_ff <= nxt_flag;
			tick_ff <= nxt_tick;
			reinit_ff <= nxt_reinit;
		end
	end

	assign counter_tick = tick_ff;
	assign counter_reinit = reinit_ff;
	assign counter_run_bit = run_ff;
	assign trigger_event_flag = flag_ff;

	hw_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ13]
		mode_sel == tst_pkg::SM_TRIGGER && eff_ff.rise |=> run_ff)
		else $error("trigger edge did not start counter");

	reinit_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ11]
		reinit_ff == $past(mode_sel == tst_pkg::SM_RESET && eff_ff.rise))
		else $error("reinit pulse wrong");

	gated_count_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
		mode_sel == tst_pkg::SM_GATED |=> tick_ff == $past(run_ff && eff_ff.level))
		else $error("gated count does not follow level");

	ext_clock_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ14]
		mode_sel == tst_pkg::SM_EXTCLK && run_ff |=> tick_ff == $past(eff_ff.rise))
		else $error("external clock tick mismatch");

	internal_clk_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
		mode_sel == tst_pkg::SM_DISABLED && run_ff |=> tick_ff)
		else $error("internal clock not counting");

	no_run_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ17]
		!run_ff |=> !tick_ff)
		else $error("counted without run bit");

	flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ18]
		flag_set |=> flag_ff)
		else $error("trigger flag not set");

	flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ18]
		flag_ff && !wr_now |=> flag_ff)
		else $error("trigger flag dropped without clear");

	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ18]
		wr_now && addr_ff == tst_pkg::STAT_OFS && !hwdata[tst_pkg::FLAG_BIT_POS] && !flag_set |=> !flag_ff)
		else $error("trigger flag not cleared by software");

endmodule : tst_trigger_ctrl

/* File: logic/tst_pkg.sv */
// shared constants, types and helpers of the timer slave trigger front end
package tst_pkg;

	// ----------------------------------------------------------------
	// register map and layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h10;
	localparam int RUN_BIT_POS = 0;
	localparam int FLAG_BIT_POS = 6;
	localparam int LEVEL_BIT_POS = 8;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic RUN_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SM_DISABLED = 3'h0,
		SM_RSV1 = 3'h1,
		SM_RSV2 = 3'h2,
		SM_RSV3 = 3'h3,
		SM_RESET = 3'h4,
		SM_GATED = 3'h5,
		SM_TRIGGER = 3'h6,
		SM_EXTCLK = 3'h7
	} tst_mode_type;

	typedef enum logic [2:0] {
		SRC_INT0 = 3'h0,
		SRC_INT1 = 3'h1,
		SRC_INT2 = 3'h2,
		SRC_INT3 = 3'h3,
		SRC_CH1_EDGE = 3'h4,
		SRC_CH1_FILT = 3'h5,
		SRC_CH2_FILT = 3'h6,
		SRC_EXT_FILT = 3'h7
	} tst_src_type;

	// gray order along idle -> write -> read wait -> read data
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_RWAIT = 2'b11,
		BUS_RDATA = 2'b10
	} tst_bus_type;

	typedef struct packed {
		logic ext_trig_polarity;
		logic ext_clk2_rsvd;
		logic [1:0] ext_trig_divider_sel;
		logic [3:0] ext_trig_filter_sel;
		logic sync_delay_enable;
		logic [2:0] trigger_source_sel;
		logic rsvd;
		logic [2:0] follower_mode_sel;
	} tst_mode_reg_type;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} tst_evt_type;

	// ----------------------------------------------------------------
	// filter decoding
	// ----------------------------------------------------------------
	function automatic logic [3:0] filt_len(input logic [3:0] code);
		case (code)
			4'h0: filt_len = 4'h1;
			4'h1: filt_len = 4'h2;
			4'h2: filt_len = 4'h4;
			4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: filt_len = 4'h8;
			4'ha, 4'hd: filt_len = 4'h5;
			default: filt_len = 4'h6;
		endcase
	endfunction : filt_len

	// mask on the free running divider: tick when masked bits are zero
	function automatic logic [4:0] filt_mask(input logic [3:0] code);
		case (code)
			4'h4, 4'h5: filt_mask = 5'h01;
			4'h6, 4'h7: filt_mask = 5'h03;
			4'h8, 4'h9: filt_mask = 5'h07;
			4'ha, 4'hb, 4'hc: filt_mask = 5'h0f;
			4'hd, 4'he, 4'hf: filt_mask = 5'h1f;
			default: filt_mask = 5'h00;
		endcase
	endfunction : filt_mask

endpackage : tst_pkg

/* File: logic/tst_ext_prescaler.sv */
// edge-counting divider for the external trigger
`timescale 1ns/1ps
module tst_ext_prescaler (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and data
	input wire logic [1:0] divider_sel,
	input wire logic trig_in,
	output logic trig_out
);

	logic prev_ff;
	logic out_ff;
	logic [1:0] cnt_ff;
	logic nxt_prev;
	logic nxt_out;
	logic [1:0] nxt_cnt;
	logic [1:0] half_m1;

	// ----------------------------------------------------------------
	// divide by 2, 4, 8: toggle after 1, 2, 4 rising edges
	// ----------------------------------------------------------------
	always_comb begin
		nxt_prev = trig_in;
		nxt_out = out_ff;
		nxt_cnt = cnt_ff;
		case (divider_sel)
			2'h1: half_m1 = 2'h0;
			2'h2: half_m1 = 2'h1;
			default: half_m1 = 2'h3;
		endcase
		if (divider_sel == 2'h0) begin
			nxt_out = trig_in; // [RQ2]
			nxt_cnt = 2'h0;
		end else if (trig_in && !prev_ff) begin
			if (cnt_ff >= half_m1) begin
				nxt_out = !out_ff; // [RQ2]
				nxt_cnt = 2'h0;
			end else begin
				nxt_cnt = cnt_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			out_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			prev_ff <= nxt_prev;
			out_ff <= nxt_out;
			cnt_ff <= nxt_cnt;
		end
	end

	assign trig_out = out_ff;

	pass_through_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
		divider_sel == 2'h0 |=> out_ff == $past(trig_in))
		else $error("undivided trigger does not follow input");

	div_two_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
		(divider_sel == 2'h1 && trig_in && !prev_ff) ##1 divider_sel == 2'h1 |-> out_ff != $past(out_ff))
		else $error("divide by two missed a toggle");

endmodule : tst_ext_prescaler

/* File: logic/tst_ext_filter.sv */
// sampled event-counter filter for the divided external trigger
`timescale 1ns/1ps
module tst_ext_filter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and data
	input wire logic [3:0] filter_sel,
	input wire logic trig_in,
	output logic trig_out
);

	logic [4:0] div_ff;
	logic [3:0] cnt_ff;
	logic out_ff;
	logic [4:0] nxt_div;
	logic [3:0] nxt_cnt;
	logic nxt_out;
	logic tick;
	logic [3:0] len;

	// ----------------------------------------------------------------
	// sample tick and agreement counter
	// ----------------------------------------------------------------
	// the base clock equals the kernel clock, so codes 0..3 sample every cycle
	always_comb begin
		len = tst_pkg::filt_len(filter_sel); // [RQ4] [RQ5] [RQ6]
		tick = (div_ff & tst_pkg::filt_mask(filter_sel)) == 5'h00; // [RQ5] [RQ6]
		nxt_div = div_ff + 5'h01;
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		if (tick) begin
			if (trig_in == out_ff) begin
				nxt_cnt = 4'h0; // [RQ20]
			end else if (cnt_ff + 4'h1 >= len) begin
				nxt_out = trig_in; // [RQ3]
				nxt_cnt = 4'h0;
			end else begin
				nxt_cnt = cnt_ff + 4'h1; // [RQ3]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 5'h00;
			cnt_ff <= 4'h0;
			out_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign trig_out = out_ff;

	change_on_count_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ20]
		out_ff != $past(out_ff) |-> $past(tick) && $past(cnt_ff) + 4'h1 >= $past(len))
		else $error("filter output changed before enough samples");

	restart_count_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ20]
		tick && trig_in == out_ff |=> cnt_ff == 4'h0)
		else $error("filter counter not restarted");

endmodule : tst_ext_filter

/* File: bench/tst_far_model.sv */
// far-side model: other timers and the external trigger pin
`timescale 1ns/1ps
module tst_far_model (
	// clock
	input wire logic clk,
	// trigger sources
	output logic ext_trig_pin,
	output logic internal_trigger_0,
	output logic internal_trigger_1,
	output logic internal_trigger_2,
	output logic internal_trigger_3,
	output logic ch1_edge_pulse,
	output logic ch1_filtered_input,
	output logic ch2_filtered_input
);
	logic pin_inv = 1'b0;

	initial begin
		{ext_trig_pin, internal_trigger_0, internal_trigger_1, internal_trigger_2} = 4'h0;
		{internal_trigger_3, ch1_edge_pulse, ch1_filtered_input, ch2_filtered_input} = 4'h0;
	end

	// levels move just after an edge, as a timer output would
	task automatic set_level(input int src, input logic v);
		@(posedge clk);
		case (src)
			0: internal_trigger_0 <= v;
			1: internal_trigger_1 <= v;
			2: internal_trigger_2 <= v;
			3: internal_trigger_3 <= v;
			5: ch1_filtered_input <= v;
			6: ch2_filtered_input <= v;
			default: ext_trig_pin <= v ^ pin_inv; // active level follows pin sense
		endcase
	endtask : set_level

	// a pulse per ch1 transition, never a level
	task automatic ch1_pulse();
		@(posedge clk);
		ch1_edge_pulse <= 1'b1;
		@(posedge clk);
		ch1_edge_pulse <= 1'b0;
	endtask : ch1_pulse

	// pin idles at its inactive level
	task automatic set_inv(input logic v);
		@(posedge clk);
		pin_inv = v;
		ext_trig_pin <= v;
	endtask : set_inv

	// period never below four clocks, so no divider is needed
	task automatic ext_burst(input int n, input int half);
		int h;
		h = (half < 2) ? 2 : half;
		repeat (n) begin
			set_level(7, 1'b1);
			repeat (h - 1) @(posedge clk);
			set_level(7, 1'b0);
			repeat (h - 1) @(posedge clk);
		end
	endtask : ext_burst
endmodule : tst_far_model

/* File: bench/tb_timer_slave_trigger_control.sv */
// self-checking bench of the slave trigger front end
`timescale 1ns/1ps
module tb_timer_slave_trigger_control;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic ext_trig_pin, internal_trigger_0, internal_trigger_1, internal_trigger_2, internal_trigger_3;
	logic ch1_edge_pulse, ch1_filtered_input, ch2_filtered_input;
	logic counter_tick, counter_reinit, counter_run_bit, trigger_event_flag;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int ticks = 0;
	int reinits = 0;
	int a, b, d0, d1;
	int filt_n [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
	int filt_r [16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
	tst_pkg::tst_mode_reg_type m = '0;

	tst_trigger_ctrl u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_trig_pin(ext_trig_pin),
		.internal_trigger_0(internal_trigger_0), .internal_trigger_1(internal_trigger_1),
		.internal_trigger_2(internal_trigger_2), .internal_trigger_3(internal_trigger_3),
		.ch1_edge_pulse(ch1_edge_pulse), .ch1_filtered_input(ch1_filtered_input),
		.ch2_filtered_input(ch2_filtered_input), .counter_tick(counter_tick),
		.counter_reinit(counter_reinit), .counter_run_bit(counter_run_bit),
		.trigger_event_flag(trigger_event_flag));

	tst_far_model u_far (.clk(clk), .ext_trig_pin(ext_trig_pin), .internal_trigger_0(internal_trigger_0),
		.internal_trigger_1(internal_trigger_1), .internal_trigger_2(internal_trigger_2),
		.internal_trigger_3(internal_trigger_3), .ch1_edge_pulse(ch1_edge_pulse),
		.ch1_filtered_input(ch1_filtered_input), .ch2_filtered_input(ch2_filtered_input));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// free-running tallies; tests take differences of snapshots
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (counter_tick === 1'b1) ticks <= ticks + 1;
		if (counter_reinit === 1'b1) reinits <= reinits + 1;
		if (cyc == 40000) begin
			err_count++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t ns: %s", $time, msg);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, ad};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0000_0000, "bus response");
	endtask : bus

	task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp, input string msg);
		bus(1'b0, ad, 32'h0000_0000);
		chk(rd, exp, msg);
	endtask : rdchk

	// source and pin sense change with the follower off, then the mode goes live
	task automatic setmode(input int src, input int sm, input int f, input int dv, input logic inv, input logic sy);
		m.follower_mode_sel = 3'h0;
		bus(1'b1, tst_pkg::MODE_OFS, {16'h0000, m}); // follower off before the source moves
		m = '0;
		m.trigger_source_sel = 3'(src);
		m.ext_trig_filter_sel = 4'(f);
		m.ext_trig_divider_sel = 2'(dv);
		m.ext_trig_polarity = inv;
		m.sync_delay_enable = sy;
		bus(1'b1, tst_pkg::MODE_OFS, {16'h0000, m}); // switch while disabled
		u_far.set_inv(inv);
		repeat (12) @(posedge clk);
		m.follower_mode_sel = 3'(sm);
		bus(1'b1, tst_pkg::MODE_OFS, {16'h0000, m});
		repeat (4) @(posedge clk);
		a = ticks;
		b = reinits;
	endtask : setmode

	task automatic poke(input int s);
		if (s == 4) begin
			u_far.ch1_pulse();
		end else begin
			u_far.set_level(s, 1'b1);
			repeat (5) @(posedge clk);
			u_far.set_level(s, 1'b0);
		end
		repeat (8) @(posedge clk);
	endtask : poke

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(tst_pkg::CTRL_OFS, 32'h0000_0000, "ctrl reset");
		rdchk(tst_pkg::MODE_OFS, {16'h0000, tst_pkg::MODE_RESET}, "mode reset");
		rdchk(tst_pkg::STAT_OFS, 32'h0000_0000, "status reset");
		bus(1'b1, 8'h04, 32'hFFFF_FFFF);
		rdchk(8'h04, tst_pkg::RDATA_RESET, "unmapped read");
		bus(1'b1, tst_pkg::MODE_OFS, 32'hFFFF_FFF8);
		rdchk(tst_pkg::MODE_OFS, 32'h0000_BFF0, "mode fields"); // field layout
		bus(1'b1, tst_pkg::MODE_OFS, 32'h0000_0000);
		bus(1'b1, tst_pkg::STAT_OFS, 32'h0000_0000);
		$display("registers done");
		bus(1'b1, tst_pkg::CTRL_OFS, 32'h0000_0001);
		for (int s = 0; s < 4; s++) begin
			setmode(0, s, 0, 0, 1'b0, 1'b0);
			repeat (20) @(posedge clk);
			chk(32'(ticks - a), 32'(20), "free count"); // kernel clock counting
		end
		bus(1'b1, tst_pkg::CTRL_OFS, 32'h0000_0000);
		repeat (2) @(posedge clk);
		a = ticks;
		repeat (20) @(posedge clk);
		chk(32'(ticks - a), 32'(0), "stopped count"); // run bit off
		$display("free mode done");
		bus(1'b1, tst_pkg::CTRL_OFS, 32'h0000_0001);
		for (int s = 0; s < 8; s++) begin
			setmode(s, 4, 0, 0, 1'b0, 1'b0);
			poke((s + 1) % 8);
			poke(s);
			chk(32'(reinits - b), 32'(1), "reinit per source"); // selected source only
			rdchk(tst_pkg::STAT_OFS, 32'h0000_0040, "flag on rise"); // rise sets flag
			bus(1'b1, tst_pkg::STAT_OFS, 32'h0000_0000);
			rdchk(tst_pkg::STAT_OFS, 32'h0000_0000, "flag clear"); // cleared by zero
		end
		$display("reset mode done");
		setmode(0, 5, 0, 0, 1'b0, 1'b0);
		u_far.set_level(0, 1'b1);
		d0 = cyc;
		repeat (6) @(posedge clk);
		rdchk(tst_pkg::STAT_OFS, 32'h0000_0140, "gate high"); // level and flag
		bus(1'b1, tst_pkg::STAT_OFS, 32'h0000_0000);
		u_far.set_level(0, 1'b0);
		d1 = cyc;
		repeat (8) @(posedge clk);
		chk(32'(ticks - a), 32'(d1 - d0), "gated count"); // counts while high, holds
		rdchk(tst_pkg::STAT_OFS, 32'h0000_0040, "flag on fall"); // any edge when gated
		chk(32'(trigger_event_flag), 32'h0000_0001, "flag pin");
		$display("gated mode done");
		bus(1'b1, tst_pkg::CTRL_OFS, 32'h0000_0000);
		setmode(1, 6, 0, 0, 1'b0, 1'b0);
		poke(1);
		rdchk(tst_pkg::CTRL_OFS, 32'h0000_0001, "run by trigger"); // hardware start
		chk(32'(counter_run_bit), 32'h0000_0001, "run pin");
		chk(32'(reinits - b), 32'(0), "start without reset"); // start only
		$display("trigger mode done");
		for (int i = 0; i < 5; i++) begin
			setmode(7, 7, 0, i % 4, i == 4, 1'b0);
			u_far.ext_burst(16, 4);
			repeat (10) @(posedge clk);
			chk(32'(ticks - a), 32'(16 >> (i % 4)), "edge count"); // divider and sense
		end
		for (int f = 0; f < 16; f++) begin
			setmode(7, 7, f, 0, 1'b0, 1'b0);
			if (filt_n[f] > 1) begin
				u_far.set_level(7, 1'b1);
				repeat ((filt_n[f] - 1) * filt_r[f] - 1) @(posedge clk);
				u_far.set_level(7, 1'b0);
			end
			repeat ((filt_n[f] + 1) * filt_r[f]) @(posedge clk);
			u_far.set_level(7, 1'b1);
			repeat ((filt_n[f] + 1) * filt_r[f]) @(posedge clk);
			u_far.set_level(7, 1'b0);
			repeat ((filt_n[f] + 1) * filt_r[f] + 6) @(posedge clk);
			chk(32'(ticks - a), 32'(1), "filter"); // glitch dropped, pulse kept
		end
		$display("external clock done");
		for (int y = 0; y < 2; y++) begin
			setmode(0, 4, 0, 0, 1'b0, y[0]);
			u_far.set_level(0, 1'b1);
			d0 = cyc;
			while (counter_reinit !== 1'b1 && cyc - d0 < 20) @(posedge clk);
			if (y == 0) begin
				d1 = cyc - d0;
				chk(32'(d1), 32'(3), "reinit latency");
			end else begin
				chk(32'(cyc - d0), 32'(d1 + 1), "sync delay"); // one clock later
			end
			u_far.set_level(0, 1'b0);
			repeat (6) @(posedge clk);
		end
		$display("sync delay done");
		wrap_up();
	end
endmodule : tb_timer_slave_trigger_control
